// >>> serial_clocked_adc_conversion.sv
// serial-clocked adc conversion sequencer with dac load and timing bookkeeping
`timescale 1ns/1ps
`default_nettype none

module serial_clocked_adc_conversion
  import sclk_conv_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               csN,
  input  wire logic               sclk,
  input  wire logic               sdi,
  output logic                    sdo,
  output logic                    sdoEn,
  input  wire logic [1:0]         clock_select,
  input  wire logic [1:0]         scan_select,
  input  wire logic [1:0]         refMode,
  input  wire logic               extRef,
  input  wire logic               bias_keep_on,
  input  wire logic [11:0]        adcResult,
  input  wire logic [11:0]        tempResult,
  input  wire logic               convert_start_pin,
  input  wire logic [TIME_W-1:0]  sampleTime,
  input  wire logic [4:0]         avgCount,
  input  wire logic [TIME_W-1:0]  extRefWake,
  input  wire logic               tempReq,
  input  wire logic               dac_load_strobe,
  input  wire logic [95:0]        dacInput,
  input  wire logic               dacCmdDone,
  output logic [95:0]             dacOutput,
  output logic                    dacSettleStart,
  output logic                    analogOn,
  output logic                    biasOn,
  output logic                    sampleHold,
  output logic [TIME_W-1:0]       scanTime,
  output logic [TIME_W-1:0]       pinConvTime,
  output logic                    wordValid,
  output logic [7:0]              wordData,
  input  wire logic               wordReady
);

  function automatic logic [15:0] frame16(input logic [11:0] d);
    frame16 = {4'h0, d}; // leading zeros then msb first
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] csS, ckS, diS, cvS, ldS;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csS <= 2'h3; ckS <= 2'h0; diS <= 2'h0; cvS <= 2'h3; ldS <= 2'h3;
    end else begin
      csS <= {csS[0], csN}; ckS <= {ckS[0], sclk}; diS <= {diS[0], sdi};
      cvS <= {cvS[0], convert_start_pin}; ldS <= {ldS[0], dac_load_strobe};
    end
  end

  logic ckD, csD, cvD;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ckD <= 1'b0; csD <= 1'b1; cvD <= 1'b1;
    end else begin
      ckD <= ckS[1]; csD <= csS[1]; cvD <= cvS[1];
    end
  end
  wire ckRise = ckS[1] & ~ckD & ~csS[1];
  wire ckFall = ~ckS[1] & ckD & ~csS[1];
  wire csRise = csS[1] & ~csD;
  wire serialMode = (clock_select == CLKSEL_SERIAL);

  ////////////////////////////////////////////////////////////////////////////
  // byte receiver; a short byte is discarded at chip-select rise
  logic [3:0] bitCnt;
  logic [7:0] shIn;
  logic       byteDone;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt <= 4'h0; shIn <= 8'h00; byteDone <= 1'b0;
    end else begin
      byteDone <= 1'b0;
      if (csS[1]) begin
        bitCnt <= 4'h0;
      end else if (ckRise) begin
        shIn <= {shIn[6:0], diS[1]};
        if (bitCnt == BYTE_BITS - 4'h1) begin
          bitCnt <= 4'h0;
          byteDone <= 1'b1;
        end else begin
          bitCnt <= bitCnt + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer of received bytes toward the register side
  logic [7:0] buf0, buf1;
  logic [1:0] bufCnt, next_bufCnt;
  wire push = byteDone & (bufCnt != 2'h2); // a byte past a full buffer is dropped
  wire pop = wordValid & wordReady;
  // fill level after this cycle's push and pop
  always_comb begin
    next_bufCnt = bufCnt + {1'b0, push} - {1'b0, pop};
  end
  // valid is registered from the next fill level so it leaves a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf0 <= 8'h00; buf1 <= 8'h00; bufCnt <= 2'h0; wordValid <= 1'b0;
    end else begin
      if (pop) buf0 <= buf1;
      if (push) begin
        if (bufCnt == 2'h0 || (bufCnt == 2'h1 && pop)) buf0 <= shIn;
        else buf1 <= shIn;
      end
      bufCnt <= next_bufCnt;
      wordValid <= (next_bufCnt != 2'h0);
    end
  end
  always_comb begin
    wordData = buf0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  seq_state_t state;
  logic [4:0]  clkCnt, byteCnt;
  logic [1:0]  nopCnt;
  logic [15:0] shOut;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE; clkCnt <= 5'h0; byteCnt <= 5'h0; nopCnt <= 2'h0;
      shOut <= 16'h0000; sdo <= 1'b0; sdoEn <= 1'b0; analogOn <= 1'b0; sampleHold <= 1'b0;
    end else begin
      sdoEn <= ~csS[1];
      case (state)
        ST_IDLE: begin
          if (byteDone && serialMode && shIn != NOP_BYTE) begin
            analogOn <= 1'b1;
            nopCnt <= 2'h0;
            clkCnt <= 5'h0;
            byteCnt <= 5'h0;
            sampleHold <= 1'b1;
            shOut <= frame16(adcResult);
            state <= tempReq ? ST_TEMP : ST_CONV;
          end else if (byteDone && shIn == NOP_BYTE && analogOn) begin
            nopCnt <= nopCnt + 2'h1;
            if (nopCnt + 2'h1 == NOP_PWRDN) analogOn <= 1'b0;
          end
        end
        ST_CONV: begin
          // the first zero byte lands inside the sixteen clocks
          if (byteDone) begin
            nopCnt <= (shIn == NOP_BYTE) ? nopCnt + 2'h1 : 2'h0;
          end
          if (ckRise) begin
            sdo <= shOut[15];
            shOut <= {shOut[14:0], 1'b0};
            sampleHold <= 1'b0;
            clkCnt <= clkCnt + 5'h1;
            if (clkCnt == CONV_CLOCKS - 5'h1) begin
              state <= ST_IDLE;
            end
          end
        end
        ST_TEMP: begin
          if (byteDone) begin
            byteCnt <= byteCnt + 5'h1;
            if (byteCnt + 5'h1 == TEMP_OUT_BYTE) shOut <= frame16(tempResult);
            if (byteCnt + 5'h1 == TEMP_BYTES) state <= ST_IDLE;
          end
          if (ckRise) begin
            sampleHold <= 1'b0;
            sdo <= (byteCnt >= TEMP_OUT_BYTE) ? shOut[15] : 1'b0;
            if (byteCnt >= TEMP_OUT_BYTE) shOut <= {shOut[14:0], 1'b0};
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // bias block stays up while requested or while the analog block is on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) biasOn <= 1'b0;
    else biasOn <= bias_keep_on | analogOn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // internally timed scan duration bookkeeping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scanTime <= '0;
    end else begin
      scanTime <= TIME_W'(sampleTime * avgCount * ((scan_select == SCAN_REPEAT) ? 2 : 1))
                + (tempReq ? TIME_W'(TEMP_CYC) : '0)
                + (extRef ? extRefWake : '0);
    end
  end

  // mode 01: duration counted over start pin low plus high spans
  logic [TIME_W-1:0] pinCnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinCnt <= '0; pinConvTime <= '0;
    end else if (!cvS[1] && cvD) begin
      pinConvTime <= pinCnt;
      pinCnt <= TIME_W'(1); // the falling-edge cycle itself counts
    end else begin
      pinCnt <= pinCnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dac update: strobe low copies, held low is transparent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dacOutput <= '0; dacSettleStart <= 1'b0;
    end else begin
      if (!ldS[1]) dacOutput <= dacInput;
      dacSettleStart <= csRise & dacCmdDone;
    end
  end

endmodule
`default_nettype wire

// >>> sclk_conv_pkg.sv
// shared constants for the serial-clocked conversion sequencer
package sclk_conv_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam logic [1:0] CLKSEL_SERIAL = 2'h3;
  localparam logic [1:0] SCAN_REPEAT = 2'h2;
  localparam logic [1:0] REFMODE_INT = 2'h0;
  localparam logic [4:0] CONV_CLOCKS = 5'h10;
  localparam logic [4:0] LEAD_ZEROS = 5'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [4:0] TEMP_BYTES = 5'h18;
  localparam logic [4:0] TEMP_OUT_BYTE = 5'h16;
  localparam logic [1:0] NOP_PWRDN = 2'h2;
  localparam logic [7:0] NOP_BYTE = 8'h00;
  localparam int unsigned TEMP_NS = 53100;
  localparam int unsigned TEMP_CYC = TEMP_NS * CLK_MHZ / 1000;
  localparam int unsigned CSHIGH_MAX_US = 100;
  localparam int unsigned REF_WAIT_US = 45;
  localparam int unsigned WAIT_CYC = REF_WAIT_US * CLK_MHZ;
  localparam int unsigned TIME_W = 24;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_CONV = 4'b0100,
    ST_TEMP = 4'b1000
  } seq_state_t;
endpackage

// >>> sclk_conv_assertions.sv
// assertion checker for the serial-clocked conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sclk_conv_assertions
  import sclk_conv_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              csN,
  input wire logic              sclk,
  input wire logic              sdo,
  input wire logic              sdoEn,
  input wire logic [1:0]        scan_select,
  input wire logic              extRef,
  input wire logic              bias_keep_on,
  input wire logic [TIME_W-1:0] sampleTime,
  input wire logic [4:0]        avgCount,
  input wire logic [TIME_W-1:0] extRefWake,
  input wire logic              tempReq,
  input wire logic              dac_load_strobe,
  input wire logic [95:0]       dacInput,
  input wire logic              dacCmdDone,
  input wire logic [95:0]       dacOutput,
  input wire logic              dacSettleStart,
  input wire logic              biasOn,
  input wire logic [TIME_W-1:0] scanTime
);
  logic [56:0]       cfg;
  logic [TIME_W-1:0] expScan;
  // scan inputs and the duration they imply
  assign cfg = {sampleTime, avgCount, scan_select, tempReq, extRef, extRefWake};
  assign expScan = TIME_W'(sampleTime * avgCount * (scan_select == SCAN_REPEAT ? 2 : 1)
    + (tempReq ? TEMP_CYC : 0) + (extRef ? extRefWake : 0));
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  AST_SDO_RISE: assert property (sdoEn && $past(sdoEn) && $changed(sdo) |-> $past(sclk, 2))
    else $error("sdo moved off a clock rise");
  AST_BIAS_KEEP: assert property (bias_keep_on [*4] |-> biasOn)
    else $error("bias dropped");
  AST_SCAN_TIME: assert property ((!tempReq && !extRef && $stable(cfg)) [*4] |-> scanTime == expScan)
    else $error("scan time wrong");
  AST_TEMP_TIME: assert property ((tempReq && $stable(cfg)) [*4] |-> scanTime == expScan)
    else $error("temperature time wrong");
  AST_EXTREF_TIME: assert property ((extRef && $stable(cfg)) [*4] |-> scanTime == expScan)
    else $error("reference wake time wrong");
  AST_SETTLE_AT_CS: assert property ($rose(dacSettleStart) |-> csN && dacCmdDone ##1 !dacSettleStart)
    else $error("settle start misplaced");
  AST_DAC_HOLD: assert property (dac_load_strobe [*6] |=> $stable(dacOutput))
    else $error("dac output moved without load");
  AST_DAC_FOLLOW: assert property ((!dac_load_strobe && $stable(dacInput)) [*6] |-> dacOutput == dacInput)
    else $error("dac not transparent");
endmodule
bind serial_clocked_adc_conversion sclk_conv_assertions u_chk (.*);
`default_nettype wire

// >>> spi_host_model.sv
// serial host model: frames bytes with its own free-phase link clock
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic      csN,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  // idle: deselected, clock parked low
  initial begin
    csN = 1'h1;
    sclk = 1'h0;
    sdi = 1'h0;
  end
  // one frame of nb bits, msb first, sdo taken at the falling clock
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    #37 csN = 1'h0;
    for (int i = 0; i < nb; i++) begin
      sdi = tx[7-i];
      #100 sclk = 1'h1;
      #100 sclk = 1'h0;
      rx = {rx[6:0], sdo};
    end
    #100 csN = 1'h1;
    sdi = ~sdi;
    #150;
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the serial-clocked conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sclk_conv_pkg::*;
  logic              clk = 1'h0, rst = 1'h1, extRef = 1'h0, bias_keep_on = 1'h0, tempReq = 1'h0;
  logic              convert_start_pin = 1'h1, dac_load_strobe = 1'h1, dacCmdDone = 1'h0, wordReady = 1'h1;
  logic [1:0]        clock_select = 2'h3, scan_select = 2'h0, refMode = 2'h1;
  logic [11:0]       adcResult = 12'h0, tempResult = 12'h0, prevAdc;
  logic [TIME_W-1:0] sampleTime = '0, extRefWake = '0, scanTime, pinConvTime;
  logic [4:0]        avgCount = 5'h1;
  logic [95:0]       dacInput = '0, dacOutput;
  logic [7:0]        wordData, rx, hi, b [3];
  logic              sdo, sdoEn, dacSettleStart, analogOn, biasOn, sampleHold, wordValid;
  wire               csN, sclk, sdi;
  int                n_fail = 0, checked = 0, settles = 0;
  // system clock and settle pulse count
  always #12.5 clk = ~clk;
  always @(posedge clk) if (dacSettleStart === 1'h1) settles++;
  serial_clocked_adc_conversion u_serial_clocked_adc_conversion (.*);
  spi_host_model u_spi_host_model (.csN, .sclk, .sdi, .sdo);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
  task automatic send(input logic [7:0] tx); u_spi_host_model.xfer(tx, 8, rx); endtask
  function automatic logic [TIME_W-1:0] expScan();
    return TIME_W'(sampleTime * avgCount * (scan_select == SCAN_REPEAT ? 2 : 1)
      + (tempReq ? TEMP_CYC : 0) + (extRef ? extRefWake : 0));
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #2ms;
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(28824));
    cyc(8);
    rst <= 1'h0;
    cyc(2);
    dacInput <= {$urandom, $urandom, $urandom};
    cyc(8);
    chk(dacOutput, 96'h0);
    dac_load_strobe <= 1'h0;
    cyc(8);
    chk(dacOutput, dacInput);
    dacInput <= ~dacInput;
    cyc(8);
    chk(dacOutput, dacInput);
    dac_load_strobe <= 1'h1;
    // scan duration over every repeat, temperature and reference choice
    for (int k = 0; k < 8; k++) begin
      sampleTime <= 24'($urandom_range(500, 1));
      avgCount <= 5'($urandom_range(31, 1));
      scan_select <= 2'(k);
      {tempReq, extRef} <= 2'(k >> 1);
      extRefWake <= 24'($urandom_range(4000));
      cyc(6);
      chk(scanTime, expScan());
    end
    {tempReq, extRef} <= 2'h0;
    // start pin falls forty cycles apart
    for (int k = 0; k < 3; k++) begin
      convert_start_pin <= 1'h0;
      cyc(2);
      convert_start_pin <= 1'h1;
      cyc(38);
    end
    chk(pinConvTime, 24'h28);
    // single conversions, full-scale first
    for (int k = 0; k < 4; k++) begin
      cyc(1);
      adcResult <= (k == 0) ? 12'hfff : 12'($urandom);
      bias_keep_on <= k[0];
      cyc(1);
      send(8'h80 | 8'($urandom));
      chk(sampleHold, 1'h1);
      send(8'h00);
      hi = rx;
      chk(sampleHold, 1'h0);
      chk(sdoEn, 1'h0);
      chk(analogOn, 1'h1);
      send(8'h00);
      chk({hi, rx}, {4'h0, adcResult});
      chk(analogOn, 1'h0);
      chk(biasOn, bias_keep_on);
    end
    // back-to-back conversions, one zero byte between commands
    cyc(1);
    adcResult <= 12'($urandom);
    cyc(1);
    send(8'h91);
    send(8'h00);
    hi = rx;
    prevAdc = adcResult;
    cyc(1);
    adcResult <= 12'($urandom);
    cyc(1);
    send(8'h92);
    chk({hi, rx}, {4'h0, prevAdc});
    chk(analogOn, 1'h1);
    send(8'h00);
    hi = rx;
    send(8'h00);
    chk({hi, rx}, {4'h0, adcResult});
    chk(analogOn, 1'h0);
    // temperature read
    cyc(1);
    tempReq <= 1'h1;
    tempResult <= 12'($urandom);
    cyc(1);
    send(8'h81);
    #46us;
    for (int k = 0; k < 24; k++) begin
      hi = rx;
      send(8'h00);
    end
    chk({hi, rx}, {4'h0, tempResult});
    // stalled receiver: cut byte lost, third byte refused
    cyc(1);
    tempReq <= 1'h0;
    clock_select <= 2'h0;
    wordReady <= 1'h0;
    u_spi_host_model.xfer(8'hff, 5, rx);
    for (int k = 0; k < 3; k++) begin
      b[k] = 8'($urandom);
      send(b[k]);
    end
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      chk(wordValid, k < 2);
      if (k < 2) chk(wordData, b[k]);
      @(posedge clk) wordReady <= 1'h1;
      @(posedge clk) wordReady <= 1'h0;
    end
    // software dac command end
    dacCmdDone <= 1'h1;
    wordReady <= 1'h1;
    send(8'h00);
    cyc(4);
    chk(settles, 1);
    finish_test();
  end
endmodule
`default_nettype wire
